// [rtl/rtcal_params.svh]
// Purpose: offsets, field positions, reset values of the calendar/alarm core
// Assumes: 8-bit register port, word address as printed
// Notes: included by the calendar core only
`ifndef RTCAL_PARAMS_SVH
`define RTCAL_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define RTCAL_OFF_CTRL2 8'h01
`define RTCAL_OFF_SEC 8'h02
`define RTCAL_OFF_MIN 8'h03
`define RTCAL_OFF_HOUR 8'h04
`define RTCAL_OFF_DAY 8'h05
`define RTCAL_OFF_WDAY 8'h06
`define RTCAL_OFF_MONTH 8'h07
`define RTCAL_OFF_YEAR 8'h08
`define RTCAL_OFF_AMIN 8'h09
`define RTCAL_OFF_AHOUR 8'h0A
`define RTCAL_OFF_ADAY 8'h0B
`define RTCAL_OFF_AWDAY 8'h0C

// ****************************************************************
// field positions
// ****************************************************************
`define RTCAL_BIT_INTEGRITY 7
`define RTCAL_BIT_CENTURY 7
`define RTCAL_BIT_DISABLE 7
`define RTCAL_BIT_AF 3
`define RTCAL_BIT_AIE 1

// ****************************************************************
// counter limits and reset values
// ****************************************************************
`define RTCAL_SEC_MAX 8'h59
`define RTCAL_MIN_MAX 8'h59
`define RTCAL_HOUR_MAX 8'h23
`define RTCAL_MONTH_MAX 8'h12
`define RTCAL_YEAR_MAX 8'h99
`define RTCAL_WDAY_MAX 3'h6
`define RTCAL_DAY_FIRST 8'h01
`define RTCAL_MONTH_FEB 5'h02
`define RTCAL_RST_DATE 8'h01
`define RTCAL_RST_ALARM 8'h80
`define RTCAL_SYNC_STAGES 2

`endif

// [rtl/rtcal_pkg.sv]
// Purpose: types of the calendar/alarm core
// Assumes: nothing
// Notes: constants live in rtcal_params.svh
package rtcal_pkg;

    // ****************************************************************
    // whole state of the core
    // ****************************************************************
    typedef struct packed {
        logic integrity;
        logic [6:0] sec;
        logic [6:0] min;
        logic [5:0] hour;
        logic [5:0] day;
        logic [2:0] wday;
        logic century;
        logic [4:0] month;
        logic [7:0] year;
        logic [7:0] amin;
        logic [7:0] ahour;
        logic [7:0] aday;
        logic [7:0] awday;
        logic af;
        logic alarm_irq_enable;
        logic [1:0] tick_sync;
        logic tick_prev;
        logic [1:0] vlow_sync;
        logic match_prev;
        logic [7:0] rdata;
    } rtcal_state_t;

endpackage

// [rtl/rtcal_bcd_step.sv]
// Purpose: one BCD counter step with wrap to a lower bound
// Assumes: value is valid BCD
// Notes: wrap is high when value equals the upper bound
`timescale 1ns/1ps
`default_nettype none

module rtcal_bcd_step (
    // counter value and bounds
    input wire logic [7:0] value_i,
    input wire logic [7:0] max_i,
    input wire logic [7:0] min_i,
    // stepped value
    output logic [7:0] next_o,
    output logic wrap_o
);

    always_comb begin
        wrap_o = (value_i == max_i);
        if (wrap_o) begin
            next_o = min_i;
        end else if (value_i[3:0] == 4'h9) begin
            next_o = {4'(value_i[7:4] + 4'h1), 4'h0};
        end else begin
            next_o = {value_i[7:4], 4'(value_i[3:0] + 4'h1)};
        end
    end

endmodule

`default_nettype wire

// [rtl/rtcal_core.sv]
// Purpose: time, calendar and alarm registers of a real-time clock
// Assumes: serial-bus slave outside presents byte reads/writes on the register port
// Notes: 1 Hz tick and low-voltage level arrive from another domain
//
// Overview of operation
// - seconds bit 7 flags time untrustworthy when one, trustworthy when zero.
// - seconds held as BCD 00..59 in bits 6..0.
// - minutes held as BCD 00..59, bit 7 unimplemented.
// - hours held 24-hour BCD 00..23 in bits 5..0, top bits unimplemented.
// - day of month held as BCD 01..31 in bits 5..0.
// - February gets day 29 when year divisible by four, including 00.
// - weekday three bits, Sunday 000 up to Saturday 110, user may reassign.
// - month held BCD 01..12 in bits 4..0.
// - month bit 7 is century, toggled on year roll 99 to 00.
// - year held as eight-bit BCD 00..99.
// - enabled alarm fields compared with time; flag set on first full match.
// - alarm flag sticks until cleared; sets again only on a fresh match.
// - alarm field with disable bit one is ignored in matching.
// - minute alarm: disable bit 7, BCD minute target in bits 6..0.
// - hour alarm: disable bit 7, BCD hour target below.
// - day alarm: disable bit 7, BCD day target below.
// - weekday alarm: disable bit 7, weekday target 0..6 below.
// - writing zero to alarm flag clears it, writing one leaves it.
// - alarm flag drives interrupt only when alarm interrupt enable is one.
`timescale 1ns/1ps
`default_nettype none
`include "rtcal_params.svh"

module rtcal_core (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // timebase and supply monitor
    input wire logic tick_1hz_i,
    input wire logic vlow_i,
    // open-drain interrupt pin
    output logic irq_n_o,
    output logic irq_oe_n_o
);

    // ****************************************************************
    // state and helpers
    // ****************************************************************
    rtcal_pkg::rtcal_state_t state_q;
    rtcal_pkg::rtcal_state_t state_d;

    localparam int NUM_CNT = 6;
    localparam int C_SEC = 0;
    localparam int C_MIN = 1;
    localparam int C_HOUR = 2;
    localparam int C_DAY = 3;
    localparam int C_MONTH = 4;
    localparam int C_YEAR = 5;
    localparam int NUM_ALM = 4;

    logic [7:0] cnt_cur [NUM_CNT];
    logic [7:0] cnt_max [NUM_CNT];
    logic [7:0] cnt_min [NUM_CNT];
    logic [7:0] cnt_next [NUM_CNT];
    logic cnt_wrap [NUM_CNT];
    logic tick_event;
    logic alarm_match;
    logic [7:0] alm_target [NUM_ALM];
    logic [6:0] alm_now [NUM_ALM];
    logic [NUM_ALM-1:0] alm_on;
    logic [NUM_ALM-1:0] alm_hit;

    // last day of a month, BCD
    function automatic logic [7:0] month_last_day(input logic [4:0] month, input logic [7:0] year);
        logic leap;
        leap = (2'(year[1:0] + {year[4], 1'b0}) == 2'b00);
        if (month == `RTCAL_MONTH_FEB) begin
            month_last_day = leap ? 8'h29 : 8'h28;
        end else if (month == 5'h04 || month == 5'h06 || month == 5'h09 || month == 5'h11) begin
            month_last_day = 8'h30;
        end else begin
            month_last_day = 8'h31;
        end
    endfunction

    // one alarm field: disabled, or target equals current value
    function automatic logic alarm_hit(input logic [7:0] target, input logic [6:0] cur);
        alarm_hit = target[`RTCAL_BIT_DISABLE] || (target[6:0] == cur);
    endfunction

    // ****************************************************************
    // bcd counters
    // ****************************************************************
    assign cnt_cur[C_SEC] = {1'b0, state_q.sec};
    assign cnt_cur[C_MIN] = {1'b0, state_q.min};
    assign cnt_cur[C_HOUR] = {2'b00, state_q.hour};
    assign cnt_cur[C_DAY] = {2'b00, state_q.day};
    assign cnt_cur[C_MONTH] = {3'b000, state_q.month};
    assign cnt_cur[C_YEAR] = state_q.year;

    assign cnt_max[C_SEC] = `RTCAL_SEC_MAX;
    assign cnt_max[C_MIN] = `RTCAL_MIN_MAX;
    assign cnt_max[C_HOUR] = `RTCAL_HOUR_MAX;
    assign cnt_max[C_DAY] = month_last_day(state_q.month, state_q.year);
    assign cnt_max[C_MONTH] = `RTCAL_MONTH_MAX;
    assign cnt_max[C_YEAR] = `RTCAL_YEAR_MAX;

    assign cnt_min[C_SEC] = 8'h00;
    assign cnt_min[C_MIN] = 8'h00;
    assign cnt_min[C_HOUR] = 8'h00;
    assign cnt_min[C_DAY] = `RTCAL_DAY_FIRST;
    assign cnt_min[C_MONTH] = `RTCAL_DAY_FIRST;
    assign cnt_min[C_YEAR] = 8'h00;

    generate
        for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
            rtcal_bcd_step u_step (
                .value_i(cnt_cur[g]),
                .max_i(cnt_max[g]),
                .min_i(cnt_min[g]),
                .next_o(cnt_next[g]),
                .wrap_o(cnt_wrap[g])
            );
        end
    endgenerate

    // ****************************************************************
    // alarm comparison
    // ****************************************************************
    assign alm_target[0] = state_q.amin;
    assign alm_target[1] = state_q.ahour;
    assign alm_target[2] = state_q.aday;
    assign alm_target[3] = state_q.awday;
    assign alm_now[0] = state_q.min;
    assign alm_now[1] = {1'b0, state_q.hour};
    assign alm_now[2] = {1'b0, state_q.day};
    assign alm_now[3] = {4'h0, state_q.wday};

    generate
        for (genvar f = 0; f < NUM_ALM; f++) begin : g_alm
            assign alm_on[f] = !alm_target[f][`RTCAL_BIT_DISABLE];
            assign alm_hit[f] = alarm_hit(alm_target[f], alm_now[f]);
        end
    endgenerate

    assign alarm_match = (|alm_on) && (&alm_hit);

    assign tick_event = state_q.tick_sync[1] && !state_q.tick_prev;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        state_d = state_q;

        // ************************************************************
        // synchronisers and edge history
        // ************************************************************
        state_d.tick_sync = {state_q.tick_sync[0], tick_1hz_i};
        state_d.tick_prev = state_q.tick_sync[1];
        state_d.vlow_sync = {state_q.vlow_sync[0], vlow_i};
        state_d.match_prev = alarm_match;

        // ************************************************************
        // time advance
        // ************************************************************
        if (tick_event) begin
            state_d.sec = cnt_next[C_SEC][6:0];
            if (cnt_wrap[C_SEC]) begin
                state_d.min = cnt_next[C_MIN][6:0];
                if (cnt_wrap[C_MIN]) begin
                    state_d.hour = cnt_next[C_HOUR][5:0];
                    if (cnt_wrap[C_HOUR]) begin
                        state_d.day = cnt_next[C_DAY][5:0];
                        state_d.wday = (state_q.wday >= `RTCAL_WDAY_MAX) ? 3'h0 : 3'(state_q.wday + 3'h1);
                        if (cnt_wrap[C_DAY]) begin
                            state_d.month = cnt_next[C_MONTH][4:0];
                            if (cnt_wrap[C_MONTH]) begin
                                state_d.year = cnt_next[C_YEAR];
                                if (cnt_wrap[C_YEAR]) begin
                                    state_d.century = !state_q.century;
                                end
                            end
                        end
                    end
                end
            end
        end

        // ************************************************************
        // register writes, which win over the tick for that register
        // ************************************************************
        if (reg_wr_i) begin
            if (reg_addr_i == `RTCAL_OFF_CTRL2) begin
                state_d.alarm_irq_enable = reg_wdata_i[`RTCAL_BIT_AIE];
                if (!reg_wdata_i[`RTCAL_BIT_AF]) begin
                    state_d.af = 1'b0;
                end
            end else if (reg_addr_i == `RTCAL_OFF_SEC) begin
                state_d.integrity = reg_wdata_i[`RTCAL_BIT_INTEGRITY];
                state_d.sec = reg_wdata_i[6:0];
            end else if (reg_addr_i == `RTCAL_OFF_MIN) begin
                state_d.min = reg_wdata_i[6:0];
            end else if (reg_addr_i == `RTCAL_OFF_HOUR) begin
                state_d.hour = reg_wdata_i[5:0];
            end else if (reg_addr_i == `RTCAL_OFF_DAY) begin
                state_d.day = reg_wdata_i[5:0];
            end else if (reg_addr_i == `RTCAL_OFF_WDAY) begin
                state_d.wday = reg_wdata_i[2:0];
            end else if (reg_addr_i == `RTCAL_OFF_MONTH) begin
                state_d.century = reg_wdata_i[`RTCAL_BIT_CENTURY];
                state_d.month = reg_wdata_i[4:0];
            end else if (reg_addr_i == `RTCAL_OFF_YEAR) begin
                state_d.year = reg_wdata_i;
            end else if (reg_addr_i == `RTCAL_OFF_AMIN) begin
                state_d.amin = reg_wdata_i;
            end else if (reg_addr_i == `RTCAL_OFF_AHOUR) begin
                state_d.ahour = reg_wdata_i;
            end else if (reg_addr_i == `RTCAL_OFF_ADAY) begin
                state_d.aday = reg_wdata_i;
            end else if (reg_addr_i == `RTCAL_OFF_AWDAY) begin
                state_d.awday = reg_wdata_i;
            end
        end

        // ************************************************************
        // hardware sets, which win over software clears
        // ************************************************************
        if (state_q.vlow_sync[1]) begin
            state_d.integrity = 1'b1;
        end
        if (alarm_match && !state_q.match_prev) begin
            state_d.af = 1'b1;
        end

        // ************************************************************
        // read data
        // ************************************************************
        if (reg_rd_i) begin
            if (reg_addr_i == `RTCAL_OFF_CTRL2) begin
                state_d.rdata = {4'h0, state_q.af, 1'b0, state_q.alarm_irq_enable, 1'b0};
            end else if (reg_addr_i == `RTCAL_OFF_SEC) begin
                state_d.rdata = {state_q.integrity, state_q.sec};
            end else if (reg_addr_i == `RTCAL_OFF_MIN) begin
                state_d.rdata = {1'b0, state_q.min};
            end else if (reg_addr_i == `RTCAL_OFF_HOUR) begin
                state_d.rdata = {2'b00, state_q.hour};
            end else if (reg_addr_i == `RTCAL_OFF_DAY) begin
                state_d.rdata = {2'b00, state_q.day};
            end else if (reg_addr_i == `RTCAL_OFF_WDAY) begin
                state_d.rdata = {5'h00, state_q.wday};
            end else if (reg_addr_i == `RTCAL_OFF_MONTH) begin
                state_d.rdata = {state_q.century, 2'b00, state_q.month};
            end else if (reg_addr_i == `RTCAL_OFF_YEAR) begin
                state_d.rdata = state_q.year;
            end else if (reg_addr_i == `RTCAL_OFF_AMIN) begin
                state_d.rdata = state_q.amin;
            end else if (reg_addr_i == `RTCAL_OFF_AHOUR) begin
                state_d.rdata = state_q.ahour;
            end else if (reg_addr_i == `RTCAL_OFF_ADAY) begin
                state_d.rdata = state_q.aday;
            end else if (reg_addr_i == `RTCAL_OFF_AWDAY) begin
                state_d.rdata = state_q.awday;
            end else begin
                state_d.rdata = 8'h00;
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_q <= '0;
            state_q.integrity <= 1'b1;
            state_q.day <= 6'(`RTCAL_RST_DATE);
            state_q.month <= 5'(`RTCAL_RST_DATE);
            state_q.amin <= `RTCAL_RST_ALARM;
            state_q.ahour <= `RTCAL_RST_ALARM;
            state_q.aday <= `RTCAL_RST_ALARM;
            state_q.awday <= `RTCAL_RST_ALARM;
            state_q.match_prev <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata_o = state_q.rdata;
    assign irq_n_o = 1'b0;
    assign irq_oe_n_o = !(state_q.af && state_q.alarm_irq_enable);

endmodule

`default_nettype wire

// [testbench/rtcal_props.sv]
// Purpose: concurrent checks on the calendar core ports
// Assumes: one clock, synchronous active-high reset
// Notes: bound to rtcal_core after the module
`timescale 1ns/1ps
`default_nettype none
module rtcal_props (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // timebase, supply, interrupt pin
    input wire logic tick_1hz_i,
    input wire logic vlow_i,
    input wire logic irq_n_o,
    input wire logic irq_oe_n_o
);
    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    sequence rd_at(a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    sequence alarm_wr;
        reg_wr_i && reg_addr_i inside {[8'h09:8'h0c]};
    endsequence
    sequence rd_same;
        reg_rd_i && reg_addr_i == $past(reg_addr_i);
    endsequence
    sequence supply_low_rd;
        reg_rd_i && reg_addr_i == 8'h02 && $past(vlow_i, 3) && $past(vlow_i, 4);
    endsequence
    sequence ctrl_rd_quiet;
        reg_rd_i && !reg_wr_i && reg_addr_i == 8'h01;
    endsequence
    AST_ALARM_RB: assert property (alarm_wr ##1 rd_same |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("alarm register readback differs");
    AST_MIN_MASK: assert property (rd_at(8'h03) |=> !reg_rdata_o[7])
        else $error("minutes bit 7 not zero");
    AST_HOUR_MASK: assert property (rd_at(8'h04) |=> reg_rdata_o[7:6] == 2'b00)
        else $error("hours top bits not zero");
    AST_DAY_MASK: assert property (rd_at(8'h05) |=> reg_rdata_o[7:6] == 2'b00)
        else $error("day top bits not zero");
    AST_WDAY_MASK: assert property (rd_at(8'h06) |=> reg_rdata_o[7:3] == 5'h00)
        else $error("weekday top bits not zero");
    AST_MON_MASK: assert property (rd_at(8'h07) |=> reg_rdata_o[6:5] == 2'b00)
        else $error("month bits 6..5 not zero");
    AST_INTEG_SET: assert property (supply_low_rd |=> reg_rdata_o[7])
        else $error("integrity flag not set by supply low");
    AST_AIE_OFF: assert property (reg_wr_i && reg_addr_i == 8'h01 && !reg_wdata_i[1] |=> irq_oe_n_o)
        else $error("interrupt driven with enable off");
    AST_IRQ_LEVEL: assert property (ctrl_rd_quiet ##1 !reg_rdata_o[1] |-> irq_oe_n_o && !irq_n_o)
        else $error("interrupt driven or data high while enable reads zero");
    AST_IRQ_ON: assert property (ctrl_rd_quiet ##1 (reg_rdata_o[3] && reg_rdata_o[1]) |-> !irq_oe_n_o)
        else $error("interrupt not driven with flag and enable set");
endmodule
bind rtcal_core rtcal_props chk_u (.clk_sys_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
    .reg_rdata_o, .tick_1hz_i, .vlow_i, .irq_n_o, .irq_oe_n_o);
`default_nettype wire

// [testbench/rtcal_bus_mst.sv]
// Purpose: serial-bus master model issuing register bytes
// Assumes: tasks are entered at a clock edge
// Notes: released lines show inverted last values
`timescale 1ns/1ps
`default_nettype none
module rtcal_bus_mst (
    // clock
    input wire logic clk_sys_i,
    // register port toward the core
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i
);
    // ****************************************************************
    // byte transfers
    // ****************************************************************
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        reg_rd_o <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        reg_addr_o <= a;
        reg_wr_o <= 1'b0;
        reg_rd_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_o <= 1'b0;
        @(posedge clk_sys_i);
        d = reg_rdata_i;
    endtask
    task automatic idle();
        reg_wr_o <= 1'b0;
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~reg_addr_o;
        reg_wdata_o <= ~reg_wdata_o;
        @(posedge clk_sys_i);
    endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: self-checking bench of the calendar core
// Assumes: register port driven by the master model
// Notes: each tick is spaced well over three clocks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef logic [7:0] rtcal_tv_t [7];
    logic clk_sys_i, reset_i, tick_1hz_i, vlow_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rv;
    logic reg_wr_i, reg_rd_i, irq_n_o, irq_oe_n_o;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    rtcal_core dut_u (.clk_sys_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
        .reg_rdata_o, .tick_1hz_i, .vlow_i, .irq_n_o, .irq_oe_n_o);
    rtcal_bus_mst mst_u (.clk_sys_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
        .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));
    // ****************************************************************
    // helpers
    // ****************************************************************
    initial clk_sys_i = 1'b0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    task automatic stop_test();
        $display("errors=%0d checks=%0d", err_count, total_checks);
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] e);
        total_checks++;
        if (seen !== e) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, e);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        mst_u.rd_reg(a, rv);
        chk(rv, e);
    endtask
    task automatic set_time(input rtcal_tv_t t);
        for (int i = 0; i < 7; i++) mst_u.wr_reg(8'h02 + 8'(i), t[i]);
    endtask
    task automatic chk_time(input rtcal_tv_t t);
        for (int i = 0; i < 7; i++) rdc(8'h02 + 8'(i), t[i]);
    endtask
    task automatic tick();
        mst_u.idle();
        tick_1hz_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        tick_1hz_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        reset_i = 1'b1;
        tick_1hz_i = 1'b0;
        vlow_i = 1'b0;
        repeat (20) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        chk_time('{8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00});
        for (int i = 0; i < 4; i++) rdc(8'h09 + 8'(i), 8'h80);
        rdc(8'h0d, 8'h00);
        mst_u.wr_reg(8'h02, 8'h00);
        rdc(8'h02, 8'h00);
        vlow_i <= 1'b1;
        repeat (4) mst_u.idle();
        rdc(8'h02, 8'h80);
        vlow_i <= 1'b0;
        repeat (3) mst_u.idle();
        rdc(8'h02, 8'h80);
        set_time('{8'h09, 8'h59, 8'h09, 8'h15, 8'h02, 8'h11, 8'h25});
        tick();
        chk_time('{8'h10, 8'h59, 8'h09, 8'h15, 8'h02, 8'h11, 8'h25});
        set_time('{8'h59, 8'h59, 8'h23, 8'h28, 8'h06, 8'h02, 8'h04});
        tick();
        chk_time('{8'h00, 8'h00, 8'h00, 8'h29, 8'h00, 8'h02, 8'h04});
        set_time('{8'h59, 8'h59, 8'h23, 8'h29, 8'h00, 8'h02, 8'h04});
        tick();
        chk_time('{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h04});
        set_time('{8'h59, 8'h59, 8'h23, 8'h28, 8'h03, 8'h02, 8'h01});
        tick();
        chk_time('{8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'h03, 8'h01});
        set_time('{8'h59, 8'h59, 8'h23, 8'h28, 8'h05, 8'h02, 8'h00});
        tick();
        chk_time('{8'h00, 8'h00, 8'h00, 8'h29, 8'h06, 8'h02, 8'h00});
        set_time('{8'h59, 8'h59, 8'h23, 8'h30, 8'h01, 8'h04, 8'h10});
        tick();
        chk_time('{8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h05, 8'h10});
        set_time('{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99});
        tick();
        chk_time('{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h81, 8'h00});
        set_time('{8'h59, 8'h59, 8'h23, 8'h31, 8'h02, 8'h92, 8'h99});
        tick();
        chk_time('{8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h01, 8'h00});
        set_time('{8'h59, 8'h04, 8'h00, 8'h15, 8'h03, 8'h06, 8'h21});
        mst_u.wr_reg(8'h09, 8'h05);
        mst_u.wr_reg(8'h0a, 8'h87);
        mst_u.wr_reg(8'h0b, 8'h15);
        mst_u.wr_reg(8'h0c, 8'h03);
        rdc(8'h0c, 8'h03);
        rdc(8'h0a, 8'h87);
        rdc(8'h01, 8'h00);
        tick();
        rdc(8'h01, 8'h08);
        chk({7'h00, irq_oe_n_o}, 8'h01);
        mst_u.wr_reg(8'h01, 8'h0a);
        rdc(8'h01, 8'h0a);
        chk({7'h00, irq_oe_n_o}, 8'h00);
        mst_u.wr_reg(8'h01, 8'h02);
        rdc(8'h01, 8'h02);
        chk({7'h00, irq_oe_n_o}, 8'h01);
        tick();
        rdc(8'h01, 8'h02);
        mst_u.wr_reg(8'h0a, 8'h07);
        rdc(8'h01, 8'h02);
        set_time('{8'h59, 8'h04, 8'h07, 8'h15, 8'h03, 8'h06, 8'h21});
        tick();
        rdc(8'h01, 8'h0a);
        chk({7'h00, irq_oe_n_o}, 8'h00);
        mst_u.wr_reg(8'h01, 8'h08);
        rdc(8'h01, 8'h08);
        chk({7'h00, irq_oe_n_o}, 8'h01);
        stop_test();
    end
endmodule
`default_nettype wire
